// ### include/joy_regs.svh
/*
 Register offsets, field positions and reset values of the joystick encoder register bank.
 Assumes it is included by bare name from the register bank module.
*/
`ifndef JOY_REGS_SVH
`define JOY_REGS_SVH

// ======================================================================
// Register offsets
`define OFS_MAKER 8'h0c
`define OFS_VERSION 8'h0d
`define OFS_STEP 8'h0e
`define OFS_CONTROL 8'h0f
`define OFS_X_RESULT 8'h10
`define OFS_Y_RESULT 8'h11
`define OFS_LEFT_THR 8'h12
`define OFS_RIGHT_THR 8'h13
`define OFS_TOP_THR 8'h14
`define OFS_BOTTOM_THR 8'h15
`define OFS_CH4_NEG_HI 8'h16
`define OFS_CH4_NEG_LO 8'h17
`define OFS_CH4_POS_HI 8'h18
`define OFS_CH4_POS_LO 8'h19
`define OFS_SCALE 8'h2d
`define OFS_POLARITY 8'h2e

// ======================================================================
// Control and polarity register field positions
`define CTL_IDLE_BIT 7
`define CTL_PERIOD_HI 6
`define CTL_PERIOD_LO 4
`define CTL_IRQ_OFF_BIT 3
`define CTL_IRQ_SEL_BIT 2
`define CTL_SOFT_RST_BIT 1
`define CTL_VALID_BIT 0
`define POL_INVERT_BIT 1

// ======================================================================
// Reset values
`define RST_CONTROL_RW 8'hf0
`define RST_RESULT 8'h00
`define RST_POS_THR 8'h05
`define RST_NEG_THR 8'hfb
`define RST_SAMPLE 12'h000
`define RST_SCALE 8'h09
`define RST_POLARITY 8'h84

`endif

// ### include/joy_pkg.sv
/*
 Types shared by the joystick encoder register bank.
 Assumes joy_regs.svh is on the include path.
*/
package joy_pkg;
    // Register address and data
    typedef logic [7:0] reg_addr_t;
    typedef logic [7:0] reg_data_t;
    // Raw channel sample
    typedef logic signed [11:0] sample_t;
    // Operating mode
    typedef enum logic {MODE_LOW_POWER, MODE_IDLE} op_mode_t;
endpackage

// ### verilog/joy_window_check.sv
/*
 Threshold window test for one new coordinate pair.
 Assumes signed two's-complement operands on the same clock.
*/
`timescale 1ns/100ps
module joy_window_check (
    // Coordinates
    input wire logic signed [7:0] x_i,
    input wire logic signed [7:0] y_i,
    // Boundaries
    input wire logic signed [7:0] left_i,
    input wire logic signed [7:0] right_i,
    input wire logic signed [7:0] top_i,
    input wire logic signed [7:0] bottom_i,
    // Result
    output logic outside_o
);
    // ==================================================================
    // Window compare
    // Left/top are positive bounds, right/bottom negative ones
    always_comb begin
        outside_o = (x_i > left_i) || (x_i < right_i) || (y_i > top_i) || (y_i < bottom_i);
    end
endmodule // joy_window_check

// ### verilog/joy_sample_split.sv
/*
 Splits a 12-bit sample into a sign-extended high byte and a low byte.
 Assumes a registered sample on its input.
*/
`timescale 1ns/100ps
module joy_sample_split (
    // Sample
    input wire logic [11:0] sample_i,
    // Bytes
    output logic [7:0] high_o,
    output logic [7:0] low_o
);
    // ==================================================================
    // Byte split
    always_comb begin
        high_o = {{4{sample_i[11]}}, sample_i[11:8]};
        low_o = sample_i[7:0];
    end
endmodule // joy_sample_split

// ### verilog/joy_register_bank.sv
/*
 Register bank of a magnetic two-axis joystick encoder.
 Assumes an I2C slave engine in front supplies byte accesses and read-done strobes,
 and a measuring core supplies results and channel-4 samples, all on CLK_I.
*/
`timescale 1ns/100ps
`include "joy_regs.svh"
module joy_register_bank #(
    parameter logic [7:0] MAKER_CODE = 8'h5a,   // Arbitrary value
    parameter logic [7:0] VERSION_CODE = 8'h31, // Arbitrary value
    parameter logic [7:0] STEP_CODE = 8'h01     // Arbitrary value
) (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RESET_I,
    // Register access from the serial slave engine
    input wire joy_pkg::reg_addr_t ADDR_I,
    input wire logic WR_STB_I,
    input wire joy_pkg::reg_data_t WR_DATA_I,
    input wire logic RD_STB_I,
    input wire logic RD_ACK_DONE_I,
    output joy_pkg::reg_data_t RD_DATA_O,
    // Measuring core
    input wire logic CALC_BUSY_I,
    input wire logic CALC_DONE_I,
    input wire logic [7:0] X_NEW_I,
    input wire logic [7:0] Y_NEW_I,
    input wire logic SAMPLE_STB_I,
    input wire joy_pkg::sample_t CH4_NEG_I,
    input wire joy_pkg::sample_t CH4_POS_I,
    // Core configuration
    output joy_pkg::op_mode_t MODE_O,
    output logic [2:0] READOUT_PERIOD_O,
    output logic [7:0] SCALE_O,
    output logic INVERT_SPIN_O,
    output logic [7:0] TEST_BITS_O,
    // Interrupt pin, open drain
    output logic MOTION_IRQ_OUT_O,
    output logic MOTION_IRQ_OUT_OE_O
);
    import joy_pkg::*;

    // ==================================================================
    // State
    logic [7:0] ctl_q;            // Writable control bits 7:2, bits 1:0 held at zero
    logic valid_q;                // Data valid flag
    logic [7:0] x_q;              // X result
    logic [7:0] y_q;              // Y result
    logic [7:0] left_q;           // Left boundary
    logic [7:0] right_q;          // Right boundary
    logic [7:0] top_q;            // Top boundary
    logic [7:0] bottom_q;         // Bottom boundary
    sample_t neg_q;               // Channel-4 negative phase
    sample_t pos_q;               // Channel-4 positive phase
    logic [7:0] scale_q;          // Coordinate scale
    logic [7:0] pol_q;            // Polarity and test bits
    logic irq_q;                  // Pending interrupt
    logic y_read_q;               // Y readback awaiting acknowledge
    reg_data_t rd_d;              // Read mux
    logic soft_rst;               // Soft reset request
    logic outside;                // Pair outside the window
    logic irq_set;                // New interrupt event
    logic [7:0] neg_hi, neg_lo, pos_hi, pos_lo;

    // Write decode
    function automatic logic wr_hit(input reg_addr_t a);
        wr_hit = WR_STB_I && (ADDR_I == a);
    endfunction
    // Soft reset when one is written into bit 1 of the control register
    assign soft_rst = wr_hit(`OFS_CONTROL) && WR_DATA_I[`CTL_SOFT_RST_BIT];

    // ==================================================================
    // Control register
    // Soft reset bit self-clears since it restores the reset value
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            ctl_q <= `RST_CONTROL_RW;
        end else if (soft_rst) begin
            ctl_q <= `RST_CONTROL_RW;
        end else if (wr_hit(`OFS_CONTROL)) begin
            ctl_q <= {WR_DATA_I[7:2], 2'b00};
        end
    end
    // Mode and readout period to the core
    assign MODE_O = ctl_q[`CTL_IDLE_BIT] ? MODE_IDLE : MODE_LOW_POWER;
    assign READOUT_PERIOD_O = ctl_q[`CTL_PERIOD_HI:`CTL_PERIOD_LO];
    // ==================================================================
    // Data valid flag
    // Cleared while the core calculates, set on completion; done wins
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            valid_q <= 1'b0;
        end else if (soft_rst) begin
            valid_q <= 1'b0;
        end else if (CALC_DONE_I) begin
            valid_q <= 1'b1;
        end else if (CALC_BUSY_I) begin
            valid_q <= 1'b0;
        end
    end
    // ==================================================================
    // Coordinate results
    // Both captured on the same done pulse so a pair never tears
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            x_q <= `RST_RESULT;
            y_q <= `RST_RESULT;
        end else if (soft_rst) begin
            x_q <= `RST_RESULT;
            y_q <= `RST_RESULT;
        end else if (CALC_DONE_I) begin
            x_q <= X_NEW_I;
            y_q <= Y_NEW_I;
        end
    end
    // ==================================================================
    // Wake thresholds
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            left_q <= `RST_POS_THR;
            right_q <= `RST_NEG_THR;
            top_q <= `RST_POS_THR;
            bottom_q <= `RST_NEG_THR;
        end else if (soft_rst) begin
            left_q <= `RST_POS_THR;
            right_q <= `RST_NEG_THR;
            top_q <= `RST_POS_THR;
            bottom_q <= `RST_NEG_THR;
        end else begin
            // One register per write
            if (wr_hit(`OFS_LEFT_THR)) begin
                left_q <= WR_DATA_I;
            end
            if (wr_hit(`OFS_RIGHT_THR)) begin
                right_q <= WR_DATA_I;
            end
            if (wr_hit(`OFS_TOP_THR)) begin
                top_q <= WR_DATA_I;
            end
            if (wr_hit(`OFS_BOTTOM_THR)) begin
                bottom_q <= WR_DATA_I;
            end
        end
    end
    // ==================================================================
    // Channel-4 samples, one per spinning phase
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            neg_q <= `RST_SAMPLE;
            pos_q <= `RST_SAMPLE;
        end else if (soft_rst) begin
            neg_q <= `RST_SAMPLE;
            pos_q <= `RST_SAMPLE;
        end else if (SAMPLE_STB_I) begin
            neg_q <= CH4_NEG_I;
            pos_q <= CH4_POS_I;
        end
    end
    // Byte views of the samples
    joy_sample_split u_neg_split (
        .sample_i(neg_q),
        .high_o(neg_hi),
        .low_o(neg_lo)
    );
    joy_sample_split u_pos_split (
        .sample_i(pos_q),
        .high_o(pos_hi),
        .low_o(pos_lo)
    );
    // ==================================================================
    // Scale and polarity registers
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            scale_q <= `RST_SCALE;
            pol_q <= `RST_POLARITY;
        end else if (soft_rst) begin
            scale_q <= `RST_SCALE;
            pol_q <= `RST_POLARITY;
        end else begin
            // Host is expected to load 06h here after power-up
            if (wr_hit(`OFS_SCALE)) begin
                scale_q <= WR_DATA_I;
            end
            // Test bits stored as written; host keeps them fixed
            if (wr_hit(`OFS_POLARITY)) begin
                pol_q <= WR_DATA_I;
            end
        end
    end
    // Configuration to the core
    assign SCALE_O = scale_q;
    assign INVERT_SPIN_O = pol_q[`POL_INVERT_BIT];
    assign TEST_BITS_O = pol_q;
    // ==================================================================
    // Interrupt
    joy_window_check u_window (
        .x_i(X_NEW_I),
        .y_i(Y_NEW_I),
        .left_i(left_q),
        .right_i(right_q),
        .top_i(top_q),
        .bottom_i(bottom_q),
        .outside_o(outside)
    );
    // New pair, optionally gated by the window, suppressed when disabled
    assign irq_set = CALC_DONE_I && !ctl_q[`CTL_IRQ_OFF_BIT] &&
                     (!ctl_q[`CTL_IRQ_SEL_BIT] || outside);
    // Remember a Y readback until its acknowledge has gone by
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            y_read_q <= 1'b0;
        end else if (RD_STB_I && ADDR_I == `OFS_Y_RESULT) begin
            y_read_q <= 1'b1;
        end else if (RD_ACK_DONE_I) begin
            y_read_q <= 1'b0;
        end
    end
    // Pending flag; a new event wins over the clear
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            irq_q <= 1'b0;
        end else if (irq_set) begin
            irq_q <= 1'b1;
        end else if (soft_rst || ctl_q[`CTL_IRQ_OFF_BIT]) begin
            irq_q <= 1'b0;
        end else if (y_read_q && RD_ACK_DONE_I) begin
            irq_q <= 1'b0;
        end
    end
    // Open drain: drive low while pending, else released
    assign MOTION_IRQ_OUT_O = 1'b0;
    assign MOTION_IRQ_OUT_OE_O = irq_q;

    // ==================================================================
    // Read mux
    always_comb begin
        case (ADDR_I)
            `OFS_MAKER: rd_d = MAKER_CODE;
            `OFS_VERSION: rd_d = VERSION_CODE;
            `OFS_STEP: rd_d = STEP_CODE;
            `OFS_CONTROL: rd_d = {ctl_q[7:2], 1'b0, valid_q};
            `OFS_X_RESULT: rd_d = x_q;
            `OFS_Y_RESULT: rd_d = y_q;
            `OFS_LEFT_THR: rd_d = left_q;
            `OFS_RIGHT_THR: rd_d = right_q;
            `OFS_TOP_THR: rd_d = top_q;
            `OFS_BOTTOM_THR: rd_d = bottom_q;
            `OFS_CH4_NEG_HI: rd_d = neg_hi;
            `OFS_CH4_NEG_LO: rd_d = neg_lo;
            `OFS_CH4_POS_HI: rd_d = pos_hi;
            `OFS_CH4_POS_LO: rd_d = pos_lo;
            `OFS_SCALE: rd_d = scale_q;
            `OFS_POLARITY: rd_d = pol_q;
            default: rd_d = 8'h00;
        endcase
    end
    // Read data registered on the read strobe
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            RD_DATA_O <= 8'h00;
        end else if (RD_STB_I) begin
            RD_DATA_O <= rd_d;
        end
    end

    // ==================================================================
    // Checks
    property p_irq_on_pair;
        @(posedge CLK_I) disable iff (RESET_I)
        (CALC_DONE_I && !ctl_q[`CTL_IRQ_OFF_BIT] && !ctl_q[`CTL_IRQ_SEL_BIT])
            |=> MOTION_IRQ_OUT_OE_O;
    endproperty
    a_irq_on_pair: assert property (p_irq_on_pair) else $error("no irq on new pair");
    property p_irq_window;
        @(posedge CLK_I) disable iff (RESET_I)
        (CALC_DONE_I && ctl_q[`CTL_IRQ_SEL_BIT] && !outside && !MOTION_IRQ_OUT_OE_O)
            |=> !MOTION_IRQ_OUT_OE_O;
    endproperty
    a_irq_window: assert property (p_irq_window) else $error("irq inside window");
    property p_irq_off;
        @(posedge CLK_I) disable iff (RESET_I)
        ($past(ctl_q[`CTL_IRQ_OFF_BIT]) && ctl_q[`CTL_IRQ_OFF_BIT]) |-> !MOTION_IRQ_OUT_OE_O;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq while disabled");
    property p_y_clear;
        @(posedge CLK_I) disable iff (RESET_I)
        (y_read_q && RD_ACK_DONE_I && !irq_set) |=> !MOTION_IRQ_OUT_OE_O;
    endproperty
    a_y_clear: assert property (p_y_clear) else $error("irq kept after Y read");
    property p_pair;
        @(posedge CLK_I) disable iff (RESET_I)
        CALC_DONE_I && !soft_rst |=> (x_q == $past(X_NEW_I)) && (y_q == $past(Y_NEW_I)) && valid_q;
    endproperty
    a_pair: assert property (p_pair) else $error("pair not captured");
    property p_soft_rst;
        @(posedge CLK_I) disable iff (RESET_I)
        soft_rst |=> (scale_q == `RST_SCALE) && (pol_q == `RST_POLARITY) &&
            (left_q == `RST_POS_THR) && (ctl_q == `RST_CONTROL_RW);
    endproperty
    a_soft_rst: assert property (p_soft_rst) else $error("soft reset incomplete");
    property p_scale;
        @(posedge CLK_I) disable iff (RESET_I)
        (WR_STB_I && ADDR_I == `OFS_SCALE && !soft_rst) |=> SCALE_O == $past(WR_DATA_I);
    endproperty
    a_scale: assert property (p_scale) else $error("scale not applied");
    property p_stable_results;
        @(posedge CLK_I) disable iff (RESET_I)
        (!CALC_DONE_I && !soft_rst) |=> $stable(x_q) && $stable(y_q);
    endproperty
    a_stable_results: assert property (p_stable_results) else $error("results moved");
    property p_id;
        @(posedge CLK_I) disable iff (RESET_I)
        (RD_STB_I && ADDR_I == `OFS_MAKER) |=> RD_DATA_O == MAKER_CODE;
    endproperty
    a_id: assert property (p_id) else $error("maker code wrong");
endmodule // joy_register_bank

// ### sim/joy_core_model.sv
/*
 Stand-in for the measuring core that feeds the register bank.
 Assumes go commands from the bench are set just after a rising edge.
*/
`timescale 1ns/100ps
module joy_core_model (
    // Clock
    input wire logic clk_i,
    // Commands from the bench
    input wire logic calc_go_i,
    input wire logic [3:0] busy_len_i,
    input wire logic [7:0] x_i,
    input wire logic [7:0] y_i,
    input wire logic smp_go_i,
    input wire logic [11:0] neg_i,
    input wire logic [11:0] pos_i,
    // Core side of the block
    output logic busy_o,
    output logic done_o,
    output logic [7:0] x_o,
    output logic [7:0] y_o,
    output logic smp_stb_o,
    output logic [11:0] neg_o,
    output logic [11:0] pos_o
);
    // ==========================================================
    // Pair: busy for busy_len_i cycles, then one cycle of done
    initial begin
        busy_o = 1'b0;
        done_o = 1'b0;
        x_o = 8'ha5;
        y_o = 8'h5a;
        forever begin
            @(posedge clk_i);
            if (calc_go_i === 1'b1) begin
                #1 busy_o = 1'b1;
                repeat (busy_len_i) @(posedge clk_i);
                #1 busy_o = 1'b0;
                done_o = 1'b1;
                x_o = x_i;
                y_o = y_i;
                @(posedge clk_i);
                // Pair is only good with done: scramble it after
                #1 done_o = 1'b0;
                x_o = ~x_o;
                y_o = ~y_o;
            end
        end
    end

    // ==========================================================
    // Channel samples: one strobe, values scrambled outside it
    initial begin
        smp_stb_o = 1'b0;
        neg_o = 12'h5a5;
        pos_o = 12'ha5a;
        forever begin
            @(posedge clk_i);
            if (smp_go_i === 1'b1) begin
                #1 smp_stb_o = 1'b1;
                neg_o = neg_i;
                pos_o = pos_i;
                @(posedge clk_i);
                #1 smp_stb_o = 1'b0;
                neg_o = ~neg_o;
                pos_o = ~pos_o;
            end
        end
    end
endmodule // joy_core_model

// ### sim/test_joy_register_bank.sv
/*
 Self-checking bench of the joystick register bank.
 Assumes joy_pkg and the core model are compiled first.
*/
`timescale 1ns/100ps
module test_joy_register_bank;
    import joy_pkg::*;
    // Arbitrary identification values
    localparam logic [7:0] MK = 8'h3c;
    localparam logic [7:0] VR = 8'h72;
    localparam logic [7:0] ST = 8'h0a;
    // Reset table, unmapped 2bh last
    logic [7:0] ra [17] = '{8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h11, 8'h12, 8'h13,
        8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h2d, 8'h2e, 8'h2b};
    logic [7:0] re [17] = '{MK, VR, ST, 8'hf0, 8'h00, 8'h00, 8'h05, 8'hfb,
        8'h05, 8'hfb, 8'h00, 8'h00, 8'h00, 8'h00, 8'h09, 8'h84, 8'h00};
    // Window cases: inside, on the edges, past each edge
    logic [7:0] wx [7] = '{8'h00, 8'h05, 8'hfb, 8'h06, 8'hfa, 8'h00, 8'h00};
    logic [7:0] wy [7] = '{8'h00, 8'h05, 8'hfb, 8'h00, 8'h00, 8'h06, 8'hfa};
    logic wi [7] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
    // Bus and model commands
    logic clk = 1'b0;
    logic rst = 1'b1;
    reg_addr_t addr = 8'h00;
    reg_data_t wdata = 8'h00;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic ack = 1'b0;
    logic calc_go = 1'b0;
    logic smp_go = 1'b0;
    logic [3:0] blen = 4'h1;
    logic [7:0] xg = 8'h00;
    logic [7:0] yg = 8'h00;
    logic [11:0] ng = 12'h000;
    logic [11:0] pg = 12'h000;
    // Wires between model and block, block outputs
    logic busy, done, sstb, inv, irq_d, irq_oe;
    logic [7:0] cx, cy, scale, test_bits;
    sample_t cneg, cpos;
    reg_data_t rdata;
    op_mode_t mode;
    logic [2:0] period;
    // Checking state
    reg_data_t exp_q[$];
    reg_data_t em;
    reg_data_t r;
    reg_data_t ctl = 8'hf0;
    logic rd_seen = 1'b0;
    int n_mismatch = 0;
    int check_count = 0;
    int k;
    integer seed = 32'h873d;

    joy_register_bank #(.MAKER_CODE(MK), .VERSION_CODE(VR), .STEP_CODE(ST)) i_joy_register_bank (
        .CLK_I(clk), .RESET_I(rst), .ADDR_I(addr), .WR_STB_I(wr_stb), .WR_DATA_I(wdata),
        .RD_STB_I(rd_stb), .RD_ACK_DONE_I(ack), .RD_DATA_O(rdata), .CALC_BUSY_I(busy),
        .CALC_DONE_I(done), .X_NEW_I(cx), .Y_NEW_I(cy), .SAMPLE_STB_I(sstb),
        .CH4_NEG_I(cneg), .CH4_POS_I(cpos), .MODE_O(mode), .READOUT_PERIOD_O(period),
        .SCALE_O(scale), .INVERT_SPIN_O(inv), .TEST_BITS_O(test_bits),
        .MOTION_IRQ_OUT_O(irq_d), .MOTION_IRQ_OUT_OE_O(irq_oe));

    joy_core_model i_joy_core_model (
        .clk_i(clk), .calc_go_i(calc_go), .busy_len_i(blen), .x_i(xg), .y_i(yg),
        .smp_go_i(smp_go), .neg_i(ng), .pos_i(pg), .busy_o(busy), .done_o(done),
        .x_o(cx), .y_o(cy), .smp_stb_o(sstb), .neg_o(cneg), .pos_o(cpos));

    // ==========================================================
    // Clock, 100 ns period
    always #50 clk = ~clk;

    // Compare one value, count it
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Byte write and byte read, strobe held over one edge
    task automatic wr(input reg_addr_t a, input reg_data_t d);
        @(posedge clk);
        #1 addr = a;
        wdata = d;
        wr_stb = 1'b1;
        @(posedge clk);
        #1 wr_stb = 1'b0;
    endtask
    task automatic rd(input reg_addr_t a, input reg_data_t e);
        @(posedge clk);
        #1 addr = a;
        rd_stb = 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        #1 rd_stb = 1'b0;
    endtask

    // Read monitor: answer stands the cycle after the strobe
    always @(posedge clk) rd_seen <= rd_stb;
    always @(negedge clk) begin
        if (rd_seen === 1'b1) begin
            em = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
            check("read data", rdata, em);
        end
    end

    // Y readback, then the acknowledge that frees the pin
    task automatic clear_irq(input reg_data_t y);
        rd(8'h11, y);
        check("irq held", {6'h00, irq_d, irq_oe}, 8'h01);
        @(posedge clk);
        #1 ack = 1'b1;
        @(posedge clk);
        #1 ack = 1'b0;
        check("irq freed", {7'h00, irq_oe}, 8'h00);
    endtask

    // One pair from the core; slow pairs also read valid while busy
    task automatic calc(input logic [7:0] x, input logic [7:0] y, input logic [3:0] len,
            input logic irq);
        @(posedge clk);
        #1 xg = x;
        yg = y;
        blen = len;
        calc_go = 1'b1;
        @(posedge clk);
        #1 calc_go = 1'b0;
        if (len > 4'h3) rd(8'h0f, ctl & 8'hfc);
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (done !== 1'b1 && k < 40);
        // A pair that never completes counts as a mismatch
        if (done !== 1'b1) n_mismatch++;
        #2 check("irq", {7'h00, irq_oe}, {7'h00, irq});
    endtask

    // Channel-4 capture and its four bytes
    task automatic sample(input logic [11:0] n, input logic [11:0] p);
        @(posedge clk);
        #1 ng = n;
        pg = p;
        smp_go = 1'b1;
        @(posedge clk);
        #1 smp_go = 1'b0;
        repeat (2) @(posedge clk);
        rd(8'h16, {{4{n[11]}}, n[11:8]});
        rd(8'h17, n[7:0]);
        rd(8'h18, {{4{p[11]}}, p[11:8]});
        rd(8'h19, p[7:0]);
    endtask

    // Verdict
    task automatic finish_test;
        if (exp_q.size() != 0) n_mismatch++;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Watchdog, sequence needs under 1500 cycles
    initial begin
        #300000;
        n_mismatch++;
        finish_test();
    end

    // ==========================================================
    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        #1 rst = 1'b0;
        check("mode", {7'h00, mode}, {7'h00, MODE_IDLE});
        check("period", {5'h00, period}, 8'h07);
        check("scale", scale, 8'h09);
        check("test bits", test_bits, 8'h84);
        check("irq", {6'h00, irq_d, irq_oe}, 8'h00);
        foreach (ra[i]) rd(ra[i], re[i]);
        // Read-only places ignore writes
        wr(8'h0c, 8'($random(seed)));
        wr(8'h10, 8'($random(seed)));
        wr(8'h17, 8'($random(seed)));
        rd(8'h0c, MK);
        rd(8'h10, 8'h00);
        rd(8'h17, 8'h00);
        for (int a = 8'h12; a <= 8'h15; a++) begin
            r = 8'($random(seed));
            wr(8'(a), r);
            rd(8'(a), r);
        end
        // Host set-up values
        wr(8'h2d, 8'h06);
        wr(8'h2e, 8'h84);
        rd(8'h2d, 8'h06);
        check("scale", scale, 8'h06);
        check("polarity", {test_bits[7:2], inv, test_bits[0]}, 8'h84);
        // Every readout period in low power mode
        for (int p = 0; p < 8; p++) begin
            wr(8'h0f, {1'b0, 3'(p), 4'h0});
            check("period", {5'h00, period}, 8'(p));
        end
        ctl = 8'h70;
        rd(8'h0f, ctl);
        check("mode", {7'h00, mode}, {7'h00, MODE_LOW_POWER});
        // Request on every pair, fast and slow
        r = 8'($random(seed));
        calc(r, ~r, 4'h1, 1'b1);
        rd(8'h0f, ctl | 8'h01);
        rd(8'h10, r);
        clear_irq(~r);
        calc(8'h81, 8'h7f, 4'h6, 1'b1);
        clear_irq(8'h7f);
        // Disable drops a pending request and blocks new ones
        calc(8'h01, 8'h02, 4'h1, 1'b1);
        ctl = 8'h78;
        wr(8'h0f, ctl);
        @(posedge clk);
        #1 check("irq off", {7'h00, irq_oe}, 8'h00);
        calc(8'h40, 8'hc0, 4'h1, 1'b0);
        rd(8'h11, 8'hc0);
        // Soft reset with a request pending
        wr(8'h0f, 8'h70);
        calc(8'h11, 8'h22, 4'h1, 1'b1);
        wr(8'h0f, 8'h72);
        @(posedge clk);
        #1 check("irq", {7'h00, irq_oe}, 8'h00);
        check("scale", scale, 8'h09);
        check("mode", {7'h00, mode}, {7'h00, MODE_IDLE});
        rd(8'h0f, 8'hf0);
        rd(8'h12, 8'h05);
        rd(8'h13, 8'hfb);
        rd(8'h11, 8'h00);
        // Window mode with reset thresholds
        ctl = 8'h74;
        wr(8'h0f, ctl);
        foreach (wx[i]) begin
            calc(wx[i], wy[i], 4'h1, wi[i]);
            if (wi[i]) clear_irq(wy[i]);
        end
        sample(12'h8f3, 12'h7a5);
        sample(12'($random(seed)), 12'($random(seed)));
        repeat (3) @(posedge clk);
        finish_test();
    end
endmodule // test_joy_register_bank
